// ==== pkg/psbc_pkg.sv ====
package psbc_pkg;
    // Geometry defaults
    localparam int ADDR_W = 20;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * LANE_W;
    localparam int MEM_WORDS = 64;
    localparam int FIFO_DEPTH = 4;
    // Burst counter covers the two low address bits
    localparam int BURST_BITS = 2;
    // Values after reset
    localparam logic RST_SELECTED = 1'b0;
    localparam logic RST_STRAP = 1'b1;

    typedef enum logic [1:0] {
        PSBC_DESEL,
        PSBC_READ,
        PSBC_WRITE
    } psbc_op_t;

    // Next address within a four-location wrap group
    function automatic logic [1:0] psbc_burst_step(input logic [1:0] base,
            input logic [1:0] cnt, input logic interleaved);
        logic [1:0] nxt;
        nxt = cnt + 2'h1;
        if (interleaved) begin
            psbc_burst_step = base ^ nxt;
        end else begin
            psbc_burst_step = base + nxt;
        end
    endfunction
endpackage

// ==== pkg/psbc_wr_if.sv ====
`timescale 1ns/1ps
// Write requests from the bus pipeline to the array
interface psbc_wr_if #(
    parameter int AW = 20,
    parameter int DW = 36,
    parameter int NL = 4
);
    logic valid;
    logic ready;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
    logic [NL-1:0] lane_en;

    modport src (output valid, output addr, output data, output lane_en,
        input ready);
    modport snk (input valid, input addr, input data, input lane_en,
        output ready);
endinterface // psbc_wr_if

// ==== hdl/psbc_fifo.sv ====
`timescale 1ns/1ps
module psbc_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] cnt_q;
    logic push;
    logic pop;

    // Honest full and empty from the occupancy count
    assign in_ready_o = (cnt_q != (PW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_q[rd_q];

    // Storage
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // Pointers and count
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule // psbc_fifo

// ==== hdl/psbc_array.sv ====
`timescale 1ns/1ps
module psbc_array
    import psbc_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int NL = LANES,
    parameter int LW = LANE_W,
    parameter int WORDS = MEM_WORDS
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    psbc_wr_if.snk wr,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [NL*LW-1:0] rd_data_o
);
    localparam int IW = $clog2(WORDS);

    logic [NL*LW-1:0] mem_q [WORDS];
    logic drain_en_q;
    logic [IW-1:0] wr_idx;

    // Drains every other cycle so a burst of writes backs up the FIFO
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            drain_en_q <= 1'b0;
        end else begin
            drain_en_q <= ~drain_en_q;
        end
    end

    assign wr.ready = drain_en_q;
    assign wr_idx = wr.addr[IW-1:0];

    // Only lanes with their select active change
    always_ff @(posedge clk_i) begin
        if (wr.valid && wr.ready) begin
            for (int l = 0; l < NL; l++) begin
                if (wr.lane_en[l]) begin
                    mem_q[wr_idx][l*LW +: LW] <= wr.data[l*LW +: LW];
                end
            end
        end
    end

    // Upper address bits above the model depth alias
    assign rd_data_o = mem_q[rd_addr_i[IW-1:0]];
endmodule // psbc_array

// ==== hdl/psbc_top.sv ====
`timescale 1ns/1ps
// Function
// - Advance high on an enabled edge steps the burst counter unless deselected.
// - Advance low loads a new address and starts a fresh access.
// - Inputs other than the burst-order strap and reset are captured only on edges with the clock qualifier low.
// - Qualifier high holds the bus pipeline state, stretching the previous cycle; the write drain and strap sampling keep running.
// - Selected only with select one low, two high, three low.
// - Output-drive input low lets data pins drive; high tristates them.
// - Pins tristate on write data, first cycle after deselect, deselected.
// - Pin data is captured into the input register on the rising edge.
// - Read data appears the cycle after its address edge.
// - Each byte lane select enables its own byte and parity bit.
// - Burst-order strap: high interleaved, low linear; resampled on every edge after two deselected address edges in a row.
module psbc_top
    import psbc_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int NL = LANES,
    parameter int LW = LANE_W,
    parameter int WORDS = MEM_WORDS,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic SYS_CLK_I,
    input wire logic RESET_N_I,
    input wire logic CLOCK_QUALIFIER_N_I,
    input wire logic ADVANCE_OR_LOAD_I,
    input wire logic SELECT_LOW_ONE_I,
    input wire logic SELECT_HIGH_TWO_I,
    input wire logic SELECT_LOW_THREE_I,
    input wire logic WRITE_N_I,
    input wire logic [NL-1:0] BYTE_LANE_WRITE_N_I,
    input wire logic [AW-1:0] ADDR_I,
    input wire logic BURST_ORDER_I,
    input wire logic OUTPUT_DRIVE_N_I,
    input wire logic [NL*LW-1:0] DATA_I,
    output logic [NL*LW-1:0] DATA_O,
    output logic DATA_OE_O,
    output logic WRITE_STALL_O
);
    localparam int DW = NL * LW;

    psbc_wr_if #(.AW(AW), .DW(DW), .NL(NL)) wr_bus ();

    logic en;
    logic selected;
    logic interleaved_q;
    psbc_op_t op_q;
    psbc_op_t data_op_q;
    logic [AW-1:0] base_q;
    logic [1:0] cnt_q;
    logic [AW-1:0] cur_addr;
    logic [AW-1:0] data_addr_q;
    logic [NL-1:0] data_lanes_q;
    logic was_desel_q;
    logic first_after_desel_q;
    logic [DW-1:0] din_q;
    logic din_valid_q;
    logic [DW-1:0] dout_q;
    logic [DW-1:0] rd_word;
    logic fifo_in_ready;
    logic [AW+NL+DW-1:0] fifo_in;
    logic [AW+NL+DW-1:0] fifo_out;

    // Clock qualifier gates the bus pipeline registers; high holds them, while the strap and write drain still update
    assign en = ~CLOCK_QUALIFIER_N_I;

    // Three selects combined at the sampling edge
    assign selected = ~SELECT_LOW_ONE_I & SELECT_HIGH_TWO_I
        & ~SELECT_LOW_THREE_I;

    // Current address: base with only the low two bits stepped
    assign cur_addr = {base_q[AW-1:BURST_BITS],
        psbc_burst_step(base_q[1:0], cnt_q, interleaved_q)};

    // Strap is resampled on every edge after two deselected address edges in a row
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            interleaved_q <= RST_STRAP;
        end else if (op_q == PSBC_DESEL && was_desel_q) begin
            interleaved_q <= BURST_ORDER_I;
        end
    end

    // Address phase: load, advance or deselect
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            op_q <= PSBC_DESEL;
            base_q <= '0;
            cnt_q <= 2'h3;
        end else if (en) begin
            if (!ADVANCE_OR_LOAD_I) begin
                if (selected) begin
                    base_q <= ADDR_I;
                    cnt_q <= 2'h3; // Step yields base itself
                    op_q <= WRITE_N_I ? PSBC_READ : PSBC_WRITE;
                end else begin
                    op_q <= PSBC_DESEL;
                end
            end else if (op_q != PSBC_DESEL) begin
                // Advance after a deselect is ignored; controller reloads
                cnt_q <= cnt_q + 2'h1;
            end
        end
    end

    // Data phase follows the address phase by one enabled edge
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            data_op_q <= PSBC_DESEL;
            data_addr_q <= '0;
            data_lanes_q <= '0;
        end else if (en) begin
            data_op_q <= op_q;
            data_addr_q <= cur_addr;
            data_lanes_q <= ~BYTE_LANE_WRITE_N_I;
        end
    end

    // Tracks the first cycle emerging from deselect
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            was_desel_q <= 1'b1;
            first_after_desel_q <= 1'b0;
        end else if (en) begin
            was_desel_q <= (op_q == PSBC_DESEL);
            first_after_desel_q <= was_desel_q && (op_q != PSBC_DESEL);
        end
    end

    // Input data register on the pins
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            din_q <= '0;
            din_valid_q <= 1'b0;
        end else begin
            din_valid_q <= 1'b0;
            if (en && !DATA_OE_O) begin
                din_q <= DATA_I;
                din_valid_q <= (op_q == PSBC_WRITE);
            end
        end
    end

    // Written words queue ahead of the array; full stalls the controller
    assign fifo_in = {data_addr_q, data_lanes_q, din_q};
    assign wr_bus.addr = fifo_out[AW+NL+DW-1 -: AW];
    assign wr_bus.lane_en = fifo_out[NL+DW-1 -: NL];
    assign wr_bus.data = fifo_out[DW-1:0];
    assign WRITE_STALL_O = ~fifo_in_ready;

    psbc_fifo #(.WIDTH(AW+NL+DW), .DEPTH(DEPTH)) u_fifo (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RESET_N_I),
        .in_valid_i(din_valid_q),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in),
        .out_valid_o(wr_bus.valid),
        .out_ready_i(wr_bus.ready),
        .out_data_o(fifo_out)
    );

    psbc_array #(.AW(AW), .NL(NL), .LW(LW), .WORDS(WORDS)) u_array (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RESET_N_I),
        .wr(wr_bus.snk),
        .rd_addr_i(cur_addr),
        .rd_data_o(rd_word)
    );

    // Output register: read data of the previous address edge
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            dout_q <= '0;
        end else if (en && op_q == PSBC_READ) begin
            dout_q <= rd_word;
        end
    end

    assign DATA_O = dout_q;

    // Drive only in a read data phase with the output-drive input low;
    // a write loaded behind a read wins the pins to avoid contention
    assign DATA_OE_O = ~OUTPUT_DRIVE_N_I
        & (data_op_q == PSBC_READ) & ~first_after_desel_q
        & (op_q != PSBC_WRITE);
endmodule // psbc_top

// ==== test/psbc_top_props.sv ====
`timescale 1ns/1ps
// Pin-level checks; internal state is inferred from input history
module psbc_top_props
    import psbc_pkg::*;
#(
    parameter int NL = LANES,
    parameter int LW = LANE_W
) (
    input wire logic SYS_CLK_I,
    input wire logic RESET_N_I,
    input wire logic CLOCK_QUALIFIER_N_I,
    input wire logic ADVANCE_OR_LOAD_I,
    input wire logic SELECT_LOW_ONE_I,
    input wire logic SELECT_HIGH_TWO_I,
    input wire logic SELECT_LOW_THREE_I,
    input wire logic WRITE_N_I,
    input wire logic OUTPUT_DRIVE_N_I,
    input wire logic [NL*LW-1:0] DATA_O,
    input wire logic DATA_OE_O
);
    default clocking @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RESET_N_I);
    // Decoded select and enabled load and advance cycles
    logic ld, sel, rd, adv;
    assign ld = !CLOCK_QUALIFIER_N_I && !ADVANCE_OR_LOAD_I;
    assign adv = !CLOCK_QUALIFIER_N_I && ADVANCE_OR_LOAD_I;
    assign sel = !SELECT_LOW_ONE_I && SELECT_HIGH_TWO_I &&
        !SELECT_LOW_THREE_I;
    assign rd = ld && sel && WRITE_N_I;
    oe_gate_a: assert property (OUTPUT_DRIVE_N_I |-> !DATA_OE_O)
        else $error("pins driven with output drive off");
    desel_hiz_a: assert property (ld && !sel ##1 !CLOCK_QUALIFIER_N_I |=> !DATA_OE_O)
        else $error("pins driven while deselected");
    write_hiz_a: assert property (ld && sel && !WRITE_N_I |=> !DATA_OE_O)
        else $error("pins driven in write data phase");
    first_hiz_a: assert property (ld && !sel ##1 rd ##1
        !CLOCK_QUALIFIER_N_I |=> !DATA_OE_O)
        else $error("pins driven on first cycle after deselect");
    adv_ignore_a: assert property (ld && !sel ##1 adv ##1
        !CLOCK_QUALIFIER_N_I |=> !DATA_OE_O)
        else $error("advance woke a deselected device");
    read_drive_a: assert property (rd ##1 rd ##1 (adv || rd) |=>
        DATA_OE_O || OUTPUT_DRIVE_N_I)
        else $error("read data not driven");
    freeze_data_a: assert property (CLOCK_QUALIFIER_N_I |=> $stable(DATA_O))
        else $error("read data moved on a masked edge");
    freeze_oe_a: assert property (CLOCK_QUALIFIER_N_I ##1
        $stable(OUTPUT_DRIVE_N_I) |-> $stable(DATA_OE_O))
        else $error("drive state moved on a masked edge");
endmodule // psbc_top_props

// ==== test/psbc_ctrl_model.sv ====
`timescale 1ns/1ps
// Controller side of the bus; ctl = {qual_n, adv, sel[2:0], write_n}
module psbc_ctrl_model
    import psbc_pkg::*;
(
    input wire logic clk_i,
    output logic cq_n_o,
    output logic adv_o,
    output logic [2:0] sel_o,
    output logic wr_n_o,
    output logic [LANES-1:0] bw_n_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] dq_o
);
    logic wr_q = 1'b0;
    initial {cq_n_o, adv_o, sel_o, wr_n_o, bw_n_o, addr_o, dq_o} = '1;
    // One bus cycle, launched just after an edge
    task automatic cyc(input logic [5:0] c, input logic [ADDR_W-1:0] a,
            input logic [LANES-1:0] b, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        #1;
        {cq_n_o, adv_o, sel_o, wr_n_o} = c;
        addr_o = a;
        bw_n_o = b;
        // Released bus toggles so stale data can never look valid
        dq_o = wr_q ? d : ~dq_o;
        if (!c[5]) wr_q = !c[4] && c[3:1] == 3'b010 && !c[0];
    endtask
endmodule // psbc_ctrl_model

// ==== test/test_pipelined_sram_bus_control.sv ====
`timescale 1ns/1ps
module test_pipelined_sram_bus_control
    import psbc_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, order = 1'b1, odn = 1'b0, seen = 1'b0;
    logic cq_n, adv, wr_n, oe, stall;
    logic [2:0] sel;
    logic [LANES-1:0] bw_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq, dout, din;
    logic [DATA_W-1:0] em [64];
    logic [31:0] seed = 32'hcc81330e;
    int miscompares = 0, checked = 0;
    // Clock and the shared data wire
    always #2.5 clk = ~clk;
    assign din = oe ? dout : dq;
    psbc_ctrl_model ctl (.clk_i(clk), .cq_n_o(cq_n), .adv_o(adv),
        .sel_o(sel), .wr_n_o(wr_n), .bw_n_o(bw_n), .addr_o(addr), .dq_o(dq));
    psbc_top dut (.SYS_CLK_I(clk), .RESET_N_I(rst_n),
        .CLOCK_QUALIFIER_N_I(cq_n), .ADVANCE_OR_LOAD_I(adv),
        .SELECT_LOW_ONE_I(sel[2]), .SELECT_HIGH_TWO_I(sel[1]),
        .SELECT_LOW_THREE_I(sel[0]), .WRITE_N_I(wr_n),
        .BYTE_LANE_WRITE_N_I(bw_n), .ADDR_I(addr), .BURST_ORDER_I(order),
        .OUTPUT_DRIVE_N_I(odn), .DATA_I(din), .DATA_O(dout),
        .DATA_OE_O(oe), .WRITE_STALL_O(stall));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Random upper bits; the array aliases them away
    function automatic logic [ADDR_W-1:0] ad(input logic [5:0] ix);
        logic [31:0] r;
        r = rnd();
        return {r[ADDR_W-7:0], ix};
    endfunction
    function automatic logic [5:0] step(input logic [5:0] b,
            input logic [1:0] n);
        return {b[5:2], order ? b[1:0] ^ n : b[1:0] + n};
    endfunction
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
            input logic [DATA_W-1:0] d, input logic [LANES-1:0] b);
        for (int l = 0; l < LANES; l++) begin
            if (!b[l]) o[l*LANE_W +: LANE_W] = d[l*LANE_W +: LANE_W];
        end
        return o;
    endfunction
    task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic end_sim();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        logic [5:0] a;
        logic [DATA_W-1:0] d;
        logic [LANES-1:0] b;
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'b1;
        for (int i = 0; i < 32; i++) begin
            a = 6'(i % 16);
            d = DATA_W'({rnd(), rnd()});
            b = i < 16 ? 4'h0 : LANES'(rnd());
            ctl.cyc(6'h04, ad(a), '1, '0);
            ctl.cyc(6'h0f, '0, b, d);
            em[a] = merge(em[a], d, b);
            chk(oe, 1'b0);
        end
        $display("writes done");
        repeat (8) ctl.cyc(6'h0f, '0, '1, '0);
        for (int i = 0; i <= 17; i++) begin
            ctl.cyc(i < 16 ? 6'h05 : 6'h0f, ad(6'(i)), '1, '0);
            odn = 1'(rnd());
            #1;
            if (i > 1) chk(dout, em[i - 2]);
            if (i > 1) chk(oe, i > 2 && !odn);
        end
        odn = 1'b0;
        $display("reads done");
        // Bursts in both orders, one masked edge in the middle
        for (int o = 0; o < 2; o++) begin
            order = 1'(o);
            ctl.cyc(6'h0f, '0, '1, '0);
            a = 6'(rnd() & 32'hf);
            ctl.cyc(6'h05, ad(a), '1, '0);
            for (int k = 0; k < 6; k++) begin
                ctl.cyc(k == 2 ? 6'h35 : k > 3 ? 6'h0f : 6'h15, '0, '1, '0);
                if (k > 0) chk(dout, em[step(a, 2'(k < 3 ? k - 1 : k - 2))]);
                if (k > 0) chk(oe, k > 1);
            end
        end
        $display("bursts done");
        for (int s = 0; s < 8; s++) begin
            ctl.cyc(6'h05, ad(6'h02), '1, '0);
            ctl.cyc({2'b00, 3'(s), 1'b1}, ad(6'h00), '1, '0);
            ctl.cyc(6'h15, '0, '1, '0);
            ctl.cyc(6'h0f, '0, '1, '0);
            chk(oe ? dout : '0, s == 2 ? em[0] : '0);
            chk(oe, s == 2);
            ctl.cyc(6'h0f, '0, '1, '0);
            chk(oe ? dout : '0, s == 2 ? em[1] : '0);
            chk(oe, s == 2);
        end
        $display("selects done");
        // Writes every cycle outrun the drain until the buffer refuses
        for (int i = 0; i < 16; i++) begin
            ctl.cyc(6'h04, ad(6'h3f), '0, DATA_W'(rnd()));
            seen = seen | stall;
        end
        chk(seen, 1'b1);
        repeat (24) ctl.cyc(6'h0f, '0, '1, '0);
        chk(stall, 1'b0);
        $display("buffer done");
        end_sim();
    end
    // Watchdog well beyond the expected 190 or so cycles
    initial begin
        #5000;
        miscompares++;
        end_sim();
    end
endmodule // test_pipelined_sram_bus_control

bind psbc_top psbc_top_props #(.NL(NL), .LW(LW)) u_props (
    .SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I),
    .CLOCK_QUALIFIER_N_I(CLOCK_QUALIFIER_N_I),
    .ADVANCE_OR_LOAD_I(ADVANCE_OR_LOAD_I),
    .SELECT_LOW_ONE_I(SELECT_LOW_ONE_I),
    .SELECT_HIGH_TWO_I(SELECT_HIGH_TWO_I),
    .SELECT_LOW_THREE_I(SELECT_LOW_THREE_I), .WRITE_N_I(WRITE_N_I),
    .OUTPUT_DRIVE_N_I(OUTPUT_DRIVE_N_I), .DATA_O(DATA_O),
    .DATA_OE_O(DATA_OE_O));
